// >>> verilog/chrc_map.svh
// Constants of the halt and run control: CSR addresses, field positions, reset values.
// Assumes a 12-bit CSR address and 32-bit CSR data from the core pipeline.
`ifndef CHRC_MAP_SVH
`define CHRC_MAP_SVH
`define CHRC_CSR_PAUSE      12'h7C2
`define CHRC_CSR_POWER      12'h7C6
`define CHRC_HALT_BIT       0
`define CHRC_ZERO32         32'h0000_0000
`define CHRC_ONE32          32'h0000_0001
`endif

// >>> verilog/chrc_pkg.sv
// Types shared by the halt and run control modules.
// Assumes nothing beyond the map header.
package chrc_pkg;
  typedef enum logic [3:0] {
    CHRC_RUN   = 4'h1,  // Running
    CHRC_DBG   = 4'h2,  // debugger_halted_state
    CHRC_QUIET = 4'h4,  // Draining before debug or power halt
    CHRC_PWR   = 4'h8   // power_halted_state
  } chrc_state_e;
endpackage : chrc_pkg

// >>> verilog/chrc_pause_counter.sv
// Pause countdown for instruction execution.
// Assumes load and freeze come from the control top on the same clock.
`timescale 1ns/1ps
`include "chrc_map.svh"
module chrc_pause_counter (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        load,
  input  wire logic [31:0] loadValue,
  input  wire logic        freeze,
  input  wire logic        anyIrq,
  output logic             pausing
);
  logic [31:0] count;
  logic [31:0] next_count;

  // Count down each clock; an interrupt ends the pause at once, a power halt freezes it
  always_comb begin
    next_count = count;
    if (load)
      next_count = loadValue;
    else if (anyIrq)
      next_count = `CHRC_ZERO32;
    else if (!freeze && count != `CHRC_ZERO32)
      next_count = count - `CHRC_ONE32;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst)
      count <= `CHRC_ZERO32;
    else
      count <= next_count;
  end

  assign pausing = (count != `CHRC_ZERO32);
endmodule : chrc_pause_counter

// >>> verilog/chrc_handshake.sv
// Four-phase acknowledge for one request line from the multi-core controller.
// Assumes the request is synchronous and held until the acknowledge is seen.
`timescale 1ns/1ps
module chrc_handshake (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic req,
  input  wire logic grant,
  output logic      ack
);
  logic next_ack;

  // Ack rises once granted and holds while the request stays high
  always_comb begin
    next_ack = ack;
    if (!req)
      next_ack = 1'b0;
    else if (grant)
      next_ack = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst)
      ack <= 1'b0;
    else
      ack <= next_ack;
  end
endmodule : chrc_handshake

// >>> verilog/chrc_core_control.sv
// Halt and run state control of a processor core.
// Assumes all inputs synchronous to sys_clk, start select already synchronised.
// Summary of operation
// - A debugger halt request moves the core into the debug halted state.
// - A controller halt while already debug halted is acknowledged with no change.
// - Controller run during a debugger operation waits for operation end and resume.
// - Debugger resume with controller halt pending keeps core halted and debug flag high.
// - Leaving debug halt drops the debug flag before acknowledging the run.
// - Halted by both, the core leaves only after both release it.
// - Power halt wakes on run request, enabled wake, timer interrupt or NMI.
// - Writing one to halt bit starts power halt after the core quiesces.
// - Halt bit writes are ignored while in debug mode.
// - Halt bit acts only on a written one and reads as zero.
// - DMA stays accepted in both halted states.
// - When power halted, the wake signal wakes the core only with both enables set.
// - Pending enabled interrupts are serviced after return to running.
// - Reserved bits of both registers read zero; fields return only legal values.
// - Pause register write stops execution; counts down; ends at zero or interrupt.
// - Pause register accepts any value and always reads zero.
// - Power halt during pause freezes the countdown until running again.
// - Pause is interruptible and reports the running state.
// - Wait-for-interrupt is a no-operation and never stops the core.
// - Power control at CSR 0x7C6, pause at 0x7C2, both reset to zero.
// - Halt ack rises after halting and stays while the halt request is high.
// - Run ack rises after resuming and drops after the request drops.
// - Start select one starts running, zero starts debug halted.
// - Breakpoint flag only for debug-halt actions, cleared on debug mode exit.
`timescale 1ns/1ps
`include "chrc_map.svh"
module chrc_core_control (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Core debugger
  input  wire logic        dbgHaltReq,
  input  wire logic        dbgResumeReq,
  input  wire logic        dbgOpBusy,
  input  wire logic        brkptDebugHalt,
  // Multi-core controller
  input  wire logic        multi_core_halt_request,
  input  wire logic        multi_core_run_request,
  input  wire logic        start_running_select,
  output logic             multi_core_halt_ack,
  output logic             multi_core_run_ack,
  output logic             in_debug_halt_indication,
  output logic             breakpoint_hit_indication,
  // Power manager and wake sources
  input  wire logic        pmuHaltReq,
  input  wire logic        pmuRunReq,
  input  wire logic        interrupt_wake_signal,
  input  wire logic        globalIrqEnable,
  input  wire logic        extIrqEnable,
  input  wire logic        timerIrq,
  input  wire logic        nonmaskable_irq_input,
  input  wire logic        anyIrq,
  input  wire logic        pipeIdle,
  input  wire logic        wfiExec,
  // CSR access port
  input  wire logic        csrWrite,
  input  wire logic        csrRead,
  input  wire logic [11:0] csrAddr,
  input  wire logic [31:0] csrWdata,
  output logic [31:0]      csrRdata,
  output logic             csrHit,
  // Status to the pipeline
  output logic             execStall,
  output logic             powerHalted,
  output logic             irqServiceEnable,
  output logic             dmaAccept
);
  chrc_pkg::chrc_state_e state;
  chrc_pkg::chrc_state_e next_state;
  logic dbgPend;
  logic next_dbgPend;
  logic mcPend;
  logic next_mcPend;
  logic brkpt;
  logic next_brkpt;
  logic started;
  logic next_started;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic haltGrant;
  logic runGrant;
  logic pausing;
  logic fwHaltWr;
  logic pauseWr;
  logic wake;

  // CSR address match, used by read and write decode
  function automatic logic chrc_hit(input logic [11:0] a, input logic [11:0] reg_addr);
    chrc_hit = (a == reg_addr);
  endfunction : chrc_hit

  // Writes to the two control registers
  assign pauseWr  = csrWrite && chrc_hit(csrAddr, `CHRC_CSR_PAUSE);
  assign fwHaltWr = csrWrite && chrc_hit(csrAddr, `CHRC_CSR_POWER)
                    && csrWdata[`CHRC_HALT_BIT]
                    && state != chrc_pkg::CHRC_DBG;

  // Wake from power halt; plain wake line needs both enables
  assign wake = pmuRunReq || timerIrq || nonmaskable_irq_input
                || (interrupt_wake_signal && globalIrqEnable && extIrqEnable);

  // Halt and run state with per-source pending flags
  always_comb begin
    next_state   = state;
    next_dbgPend = dbgPend;
    next_mcPend  = mcPend;
    next_started = 1'b1;
    if (!started) begin
      next_state   = start_running_select ? chrc_pkg::CHRC_RUN
                                          : chrc_pkg::CHRC_DBG;
      next_dbgPend = !start_running_select;
    end else begin
      // Sources are tracked separately; set wins over release for the debugger
      if (multi_core_halt_request)
        next_mcPend = 1'b1;
      else if (multi_core_run_request)
        next_mcPend = 1'b0;
      if (dbgHaltReq)
        next_dbgPend = 1'b1;
      else if (dbgResumeReq && !dbgOpBusy)
        next_dbgPend = 1'b0;
      case (state)
        chrc_pkg::CHRC_RUN: begin
          // WFI has no effect here; pause keeps the running state
          if (next_dbgPend || next_mcPend)
            next_state = chrc_pkg::CHRC_QUIET;
          else if (pmuHaltReq || fwHaltWr)
            next_state = chrc_pkg::CHRC_QUIET;
        end
        chrc_pkg::CHRC_QUIET: begin
          // Drain the pipeline before reporting any halt
          if (pipeIdle)
            next_state = (next_dbgPend || next_mcPend) ? chrc_pkg::CHRC_DBG
                                                       : chrc_pkg::CHRC_PWR;
        end
        chrc_pkg::CHRC_PWR: begin
          // Debug requests override the power halt
          if (next_dbgPend || next_mcPend)
            next_state = chrc_pkg::CHRC_DBG;
          else if (wake)
            next_state = chrc_pkg::CHRC_RUN;
        end
        chrc_pkg::CHRC_DBG: begin
          if (!next_dbgPend && !next_mcPend)
            next_state = chrc_pkg::CHRC_RUN;
        end
        default: next_state = chrc_pkg::CHRC_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state   <= chrc_pkg::CHRC_DBG;
      dbgPend <= 1'b0;
      mcPend  <= 1'b0;
      started <= 1'b0;
    end else begin
      state   <= next_state;
      dbgPend <= next_dbgPend;
      mcPend  <= next_mcPend;
      started <= next_started;
    end
  end

  // Ack grants; run ack only once the debug flag is already low
  assign haltGrant = (state == chrc_pkg::CHRC_DBG);
  assign runGrant  = (state == chrc_pkg::CHRC_RUN) && !in_debug_halt_indication;

  chrc_handshake haltHs (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .req     (multi_core_halt_request),
    .grant   (haltGrant),
    .ack     (multi_core_halt_ack)
  );

  chrc_handshake runHs (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .req     (multi_core_run_request),
    .grant   (runGrant),
    .ack     (multi_core_run_ack)
  );

  // Pause countdown frozen outside the running state
  chrc_pause_counter pauseCnt (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .load      (pauseWr),
    .loadValue (csrWdata),
    .freeze    (state != chrc_pkg::CHRC_RUN),
    .anyIrq    (anyIrq),
    .pausing   (pausing)
  );

  // Breakpoint flag: set on debug-halt actions, cleared when debug mode ends
  always_comb begin
    next_brkpt = brkpt;
    if (brkptDebugHalt)
      next_brkpt = 1'b1;
    else if (state != chrc_pkg::CHRC_DBG && next_state != chrc_pkg::CHRC_DBG
             && !(state == chrc_pkg::CHRC_QUIET))
      next_brkpt = 1'b0;
  end

  // Both registers read as zero; only the hit is reported
  always_comb begin
    next_rdata = `CHRC_ZERO32;
    if (csrRead && chrc_hit(csrAddr, `CHRC_CSR_POWER))
      next_rdata = `CHRC_ZERO32;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      brkpt <= 1'b0;
      rdata <= `CHRC_ZERO32;
      in_debug_halt_indication <= 1'b0;
    end else begin
      brkpt <= next_brkpt;
      rdata <= next_rdata;
      in_debug_halt_indication <= (next_state == chrc_pkg::CHRC_DBG);
    end
  end

  assign breakpoint_hit_indication = brkpt;
  assign csrRdata = rdata;
  assign csrHit   = chrc_hit(csrAddr, `CHRC_CSR_POWER) || chrc_hit(csrAddr, `CHRC_CSR_PAUSE);
  // Stall covers halts and pauses; WFI is not an input to the stall
  assign execStall   = (state != chrc_pkg::CHRC_RUN) || pausing || !started;
  assign powerHalted = (state == chrc_pkg::CHRC_PWR);
  // Low-priority interrupts are held off while halted, then taken once running
  assign irqServiceEnable = (state == chrc_pkg::CHRC_RUN) && started;
  assign dmaAccept = 1'b1;
endmodule : chrc_core_control

// >>> tb/chrc_core_control_asserts.sv
// Port checker of the halt and run control.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ps
module chrc_core_control_asserts (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        dbgOpBusy,
  input wire logic        multi_core_halt_request,
  input wire logic        multi_core_run_request,
  input wire logic        multi_core_halt_ack,
  input wire logic        multi_core_run_ack,
  input wire logic        in_debug_halt_indication,
  input wire logic [11:0] csrAddr,
  input wire logic [31:0] csrRdata,
  input wire logic        csrHit
);
  // Core clock only, quiet while reset is low
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  halt_ack_hold_a: assert property (multi_core_halt_ack && multi_core_halt_request |=>
    multi_core_halt_ack) else $error("halt ack dropped early");
  halt_ack_drop_a: assert property (!multi_core_halt_request && multi_core_halt_ack |=>
    !multi_core_halt_ack) else $error("halt ack held late");
  run_ack_drop_a: assert property (!multi_core_run_request && multi_core_run_ack |=>
    !multi_core_run_ack) else $error("run ack held late");
  run_ack_order_a: assert property ($rose(multi_core_run_ack) |->
    !$past(in_debug_halt_indication)) else $error("run ack before debug flag fell");
  halt_ack_state_a: assert property ($rose(multi_core_halt_ack) |->
    in_debug_halt_indication) else $error("halt ack outside debug halt");
  busy_stays_a: assert property (in_debug_halt_indication && dbgOpBusy |=>
    in_debug_halt_indication) else $error("left halt during debugger operation");
  rdata_zero_a: assert property (csrRdata == 32'h0000_0000)
    else $error("register read not zero");
  csr_decode_a: assert property (csrHit == (csrAddr == 12'h7C2 || csrAddr == 12'h7C6))
    else $error("register decode wrong");
endmodule : chrc_core_control_asserts
bind chrc_core_control chrc_core_control_asserts i_chk (.sys_clk, .nrst, .dbgOpBusy,
  .multi_core_halt_request, .multi_core_run_request, .multi_core_halt_ack,
  .multi_core_run_ack, .in_debug_halt_indication, .csrAddr, .csrRdata, .csrHit);

// >>> tb/chrc_mpc_model.sv
// Behavioural multi-core controller driving the halt and run handshakes.
// Assumes the bench calls its tasks from one process, one request at a time.
`timescale 1ns/1ps
module chrc_mpc_model (
  input wire logic sys_clk,
  input wire logic haltAck,
  input wire logic runAck,
  output logic     haltReq,
  output logic     runReq
);
  // Both requests idle low from time zero
  initial {haltReq, runReq} = 2'h0;
  // Raise one request; the other is already released
  task automatic raise(input bit run);
    @(posedge sys_clk);
    #2;
    if (run) runReq = 1'b1;
    else haltReq = 1'b1;
  endtask : raise
  // Wait for the ack, linger to play a slow controller, release only once acked
  task automatic finish(input bit run, input int linger, output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge sys_clk);
      ok = run ? runAck : haltAck;
    end
    repeat (linger) @(posedge sys_clk);
    #2;
    if (ok && run) runReq = 1'b0;
    if (ok && !run) haltReq = 1'b0;
  endtask : finish
endmodule : chrc_mpc_model

// >>> tb/testbench.sv
// Self-checking bench of the halt and run control.
// Assumes design, checker and controller model are compiled first.
`timescale 1ns/1ps
module testbench;
  logic        sys_clk, nrst, dbgHaltReq, dbgResumeReq, dbgOpBusy, brkptDebugHalt;
  logic        multi_core_halt_request, multi_core_run_request, start_running_select;
  logic        multi_core_halt_ack, multi_core_run_ack, in_debug_halt_indication;
  logic        breakpoint_hit_indication, pmuHaltReq, pmuRunReq, interrupt_wake_signal;
  logic        globalIrqEnable, extIrqEnable, timerIrq, nonmaskable_irq_input, anyIrq;
  logic        pipeIdle, wfiExec, csrWrite, csrRead, csrHit, execStall, powerHalted;
  logic        irqServiceEnable, dmaAccept;
  logic [11:0] csrAddr;
  logic [31:0] csrWdata, csrRdata, cnt, rd;
  int          failures, n_tests;
  bit          ok;
  chrc_core_control i_chrc_core_control (.sys_clk, .nrst, .dbgHaltReq, .dbgResumeReq,
    .dbgOpBusy, .brkptDebugHalt, .multi_core_halt_request, .multi_core_run_request,
    .start_running_select, .multi_core_halt_ack, .multi_core_run_ack,
    .in_debug_halt_indication, .breakpoint_hit_indication, .pmuHaltReq, .pmuRunReq,
    .interrupt_wake_signal, .globalIrqEnable, .extIrqEnable, .timerIrq,
    .nonmaskable_irq_input, .anyIrq, .pipeIdle, .wfiExec, .csrWrite, .csrRead, .csrAddr,
    .csrWdata, .csrRdata, .csrHit, .execStall, .powerHalted, .irqServiceEnable, .dmaAccept);
  chrc_mpc_model i_mpc (.sys_clk, .haltAck(multi_core_halt_ack),
    .runAck(multi_core_run_ack), .haltReq(multi_core_halt_request),
    .runReq(multi_core_run_request));
  // 40 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Inputs move 2 ns after the edge so no race with the design's sampling
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask : tick
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic expHit(input logic [11:0] a);
    return a == 12'h7C2 || a == 12'h7C6;
  endfunction : expHit
  // One register access; read data stands only in the cycle after the strobe, so take it there
  task automatic csr(input logic wr, input logic [11:0] a, input logic [31:0] d);
    csrWrite = wr;
    csrRead = ~wr;
    csrAddr = a;
    csrWdata = d;
    tick(1);
    rd = csrRdata;
    csrWrite = 1'b0;
    csrRead = 1'b0;
    // Let an edge pass so a following access never re-raises a strobe in the same step
    tick(1);
  endtask : csr
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(3);
  endtask : pulse
  task automatic rst(input logic sel);
    nrst = 1'b0;
    start_running_select = sel;
    tick(8);
    nrst = 1'b1;
    tick(2);
  endtask : rst
  task automatic mpcHalt();
    i_mpc.raise(1'b0);
    i_mpc.finish(1'b0, $urandom_range(3), ok);
    chk("halt ack", 1, ok);
    tick(2);
    chk("halt ack drop", 0, multi_core_halt_ack);
  endtask : mpcHalt
  // Wake source k: power run, enabled wake, timer, non-maskable
  task automatic src(input int k, input logic v);
    case (k)
      0: pmuRunReq = v;
      1: {interrupt_wake_signal, globalIrqEnable, extIrqEnable} = {3{v}};
      2: timerIrq = v;
      default: nonmaskable_irq_input = v;
    endcase
  endtask : src
  task automatic results();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // Main sequence
  initial begin
    {nrst, dbgHaltReq, dbgResumeReq, dbgOpBusy, brkptDebugHalt, pmuHaltReq, pmuRunReq,
     interrupt_wake_signal, globalIrqEnable, extIrqEnable, timerIrq, nonmaskable_irq_input,
     anyIrq, wfiExec, csrWrite, csrRead, csrAddr, csrWdata, start_running_select} = '0;
    pipeIdle = 1'b1;
    void'($urandom(26893));
    rst(1'b0);
    chk("start halted", 1, in_debug_halt_indication);
    rst(1'b1);
    chk("start running", 0, in_debug_halt_indication);
    $display("test start done");
    for (int m = 0; m < 4; m++) begin
      if (m[0]) mpcHalt();
      dbgHaltReq = 1'b1;
      pulse(brkptDebugHalt);
      dbgHaltReq = 1'b0;
      chk("debug halted", 1, in_debug_halt_indication);
      chk("break flag set", 1, breakpoint_hit_indication);
      if (!m[0]) mpcHalt();
      csr(1'b1, 12'h7C6, 32'h0000_0001);
      if (m[1]) begin
        dbgOpBusy = 1'b1;
        i_mpc.raise(1'b1);
        dbgResumeReq = 1'b1;
        tick(6);
        chk("busy halt", 1, in_debug_halt_indication);
        chk("busy run ack", 0, multi_core_run_ack);
        dbgOpBusy = 1'b0;
        tick(2);
        dbgResumeReq = 1'b0;
      end else begin
        pulse(dbgResumeReq);
        tick(2);
        chk("held by controller", 1, in_debug_halt_indication);
        i_mpc.raise(1'b1);
      end
      i_mpc.finish(1'b1, m, ok);
      chk("run ack", 1, ok);
      chk("left halt", 0, in_debug_halt_indication);
      tick(6);
      chk("run ack drop", 0, multi_core_run_ack);
      chk("halt write ignored", 0, powerHalted);
      chk("break flag clear", 0, breakpoint_hit_indication);
      $display("test order %0d done", m);
    end
    for (int k = 0; k < 4; k++) begin
      csr(1'b1, 12'h7C6, $urandom & 32'hFFFF_FFFE);
      tick(2);
      chk("zero bit no halt", 0, powerHalted);
      csr(1'b1, 12'h7C6, $urandom | 32'h0000_0001);
      tick(4);
      chk("power halted", 1, powerHalted);
      chk("dma open", 1, dmaAccept);
      csr(1'b0, 12'h7C6, 32'h0000_0000);
      chk("halt bit read", 0, rd);
      cnt = $urandom_range(2);
      {interrupt_wake_signal, globalIrqEnable, extIrqEnable} = {1'b1, cnt[1:0]};
      tick(5);
      chk("wake masked", 1, powerHalted);
      src(1, 1'b0);
      src(k, 1'b1);
      tick(4);
      chk("woken", 0, powerHalted);
      chk("irq service", 1, irqServiceEnable);
      src(k, 1'b0);
      tick(2);
    end
    $display("test power done");
    cnt = $urandom_range(10, 3);
    csr(1'b1, 12'h7C2, cnt);
    chk("pausing", 1, execStall);
    chk("pause runs", 0, powerHalted | in_debug_halt_indication);
    csr(1'b0, 12'h7C2, 32'h0000_0000);
    chk("pause read", 0, rd);
    tick(cnt + 4);
    chk("pause over", 0, execStall);
    csr(1'b1, 12'h7C2, 32'hFFFF_FFFF);
    pulse(anyIrq);
    chk("pause cut", 0, execStall);
    csr(1'b1, 12'h7C2, 32'h0000_0014);
    pmuHaltReq = 1'b1;
    tick(4);
    pmuHaltReq = 1'b0;
    tick(40);
    pulse(pmuRunReq);
    chk("pause frozen", 1, execStall);
    tick(25);
    chk("pause resumed", 0, execStall);
    wfiExec = 1'b1;
    tick(3);
    chk("wfi no stop", 0, execStall);
    wfiExec = 1'b0;
    for (int i = 0; i < 8; i++) begin
      csrAddr = (i < 2) ? (i ? 12'h7C6 : 12'h7C2) : 12'($urandom);
      tick(1);
      chk("csr hit", expHit(csrAddr), csrHit);
    end
    $display("test pause done");
    results();
  end
  // Cut a hang short
  initial begin
    tick(20000);
    failures++;
    results();
  end
endmodule : testbench
